// >>> verilog/fault_routing_pkg.sv
`default_nettype none
package fault_routing_pkg;
   // ********************************************
   // Bus geometry and register map
   // ********************************************
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int ENGINES = 4;
   localparam int MODULES = 4;
   localparam int DIG_CMP = 4;
   localparam int ANA_CMP = 7;
   localparam int EXT_PINS = 4;
   localparam int ERROR_ADC_W = 9;
   localparam int CNT_W = 4;
   // Event vector layout
   localparam int EV_DIG = 0;
   localparam int EV_ANA = EV_DIG + DIG_CMP;
   localparam int EV_EXT = EV_ANA + ANA_CMP;
   localparam int EV_PWM = EV_EXT + EXT_PINS;
   localparam int PWM_EV = 5;
   localparam int EV_CLK = EV_PWM + PWM_EV;
   localparam int EV_DCM = EV_CLK + 2;
   localparam int EVENTS = EV_DCM + 1;
   // Module order inside an engine
   localparam int MOD_CYCLE_BY_CYCLE = 0;
   localparam int MOD_AB = 1;
   localparam int MOD_A = 2;
   localparam int MOD_B = 3;
   // Registers: byte addresses
   localparam logic [ADDR_W-1:0] REG_CTRL = 12'h000;
   localparam logic [ADDR_W-1:0] REG_STATUS = 12'h004;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 12'h008;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 12'h00c;
   localparam logic [ADDR_W-1:0] REG_EXT_CFG = 12'h010;
   localparam logic [ADDR_W-1:0] REG_PWM_CFG = 12'h014;
   localparam logic [ADDR_W-1:0] REG_ANA_CFG = 12'h018;
   localparam logic [ADDR_W-1:0] REG_DIG_BASE = 12'h040;
   localparam logic [ADDR_W-1:0] REG_ROUTE_BASE = 12'h080;
   localparam logic [ADDR_W-1:0] REG_LIMIT_BASE = 12'h0c0;
   localparam int ROUTE_REGS = ENGINES * MODULES;
   // Digital comparator register fields
   localparam int DIG_EN_BIT = 16;
   localparam int DIG_ABOVE_BIT = 17;
   // External pin config fields: enable low nibble, polarity from bit 8
   localparam int EXT_POL_LSB = 8;
   localparam logic [DATA_W-1:0] RESET_ZERO = 32'h0000_0000;
   // Bus answer
   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic err;
   } bus_answer_t;
   // Per-engine inputs
   typedef struct packed {
      logic channel_enable;
      logic cycle_start;
      logic pcm_trip;
   } engine_ctrl_t;
endpackage
`default_nettype wire

// >>> verilog/fault_routing_protection.sv
// Operation
// R1 - Four identical fault modules per engine
// R2 - Immediate detection, once per switching cycle
// R3 - Flag when consecutive faults exceed limit
// R4 - Fault-free cycle returns counter to zero
// R5 - Flag holds until channel enable low; the code also clears it when the global fault enable is low
// R6 - Enable low clears all four flags
// R7 - One global fault enable gates all; the code gates the fault modules only, and pcm_trip truncation is not gated
// R8 - One cycle-by-cycle block per engine
// R9 - Cycle-by-cycle block reacts to peak current
// R10 - Asserted fault shuts its PWM output
// R11 - Each fault input ORs selected events
// R12 - One source routable to many engines
// R13 - Four error ADC threshold comparators
// R14 - Seven fast analog comparator events
// R15 - External pins programmable as sources
// R16 - Five PWM-derived fault events
// R17 - High and low oscillator failure events
// R18 - Discontinuous conduction detector event
`default_nettype none
module fault_routing_protection (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   // APB slave
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [fault_routing_pkg::ADDR_W-1:0] PADDR_IN,
   input wire logic [fault_routing_pkg::DATA_W-1:0] PWDATA_IN,
   output logic [fault_routing_pkg::DATA_W-1:0] PRDATA_OUT,
   output logic PREADY_OUT,
   output logic PSLVERR_OUT,
   // Fault sources
   input wire logic [fault_routing_pkg::ENGINES*fault_routing_pkg::ERROR_ADC_W-1:0] ERROR_ADC_IN,
   input wire logic [fault_routing_pkg::ANA_CMP-1:0] ANALOG_CMP_IN,
   input wire logic [fault_routing_pkg::EXT_PINS-1:0] EXT_FAULT_PIN_IN,
   input wire logic [fault_routing_pkg::PWM_EV-1:0] PWM_EVENT_IN,
   input wire logic HF_OSC_FAIL_IN,
   input wire logic LF_OSC_FAIL_IN,
   input wire logic DCM_DETECT_IN,
   // PWM engines
   input wire fault_routing_pkg::engine_ctrl_t [fault_routing_pkg::ENGINES-1:0] ENGINE_IN,
   output logic [fault_routing_pkg::ENGINES-1:0] SHUTDOWN_A_OUT,
   output logic [fault_routing_pkg::ENGINES-1:0] SHUTDOWN_B_OUT,
   output logic [fault_routing_pkg::ENGINES-1:0] CYCLE_BY_CYCLE_TRUNC_OUT,
   output logic [fault_routing_pkg::ENGINES*fault_routing_pkg::MODULES-1:0] FAULT_FLAG_OUT,
   // Interrupt
   output logic IRQ_OUT
);
   // Short local names for package sizes
   localparam int NE = fault_routing_pkg::ENGINES;
   localparam int NM = fault_routing_pkg::MODULES;
   localparam int NV = fault_routing_pkg::EVENTS;
   localparam int NF = NE * NM;
   localparam int CW = fault_routing_pkg::CNT_W;
   localparam int DW = fault_routing_pkg::DATA_W;
   localparam int AW = fault_routing_pkg::ADDR_W;
   localparam int EW = fault_routing_pkg::ERROR_ADC_W;

   // ********************************************
   // Pin synchronisers
   // ********************************************
   localparam int NPIN = fault_routing_pkg::ANA_CMP + fault_routing_pkg::EXT_PINS + 3;
   // First and second synchroniser stages
   logic [NPIN-1:0] pin_meta;
   logic [NPIN-1:0] pin_sync;
   // Order: comparators, pins, oscillators, conduction
   wire [NPIN-1:0] pin_raw = {DCM_DETECT_IN, LF_OSC_FAIL_IN, HF_OSC_FAIL_IN, EXT_FAULT_PIN_IN, ANALOG_CMP_IN};

   // Two stages before any logic looks at the pins
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_raw;
         pin_sync <= pin_meta;
      end
   end

   // ********************************************
   // Registers
   // ********************************************
   // Global settings and source enables
   logic global_fault_enable;
   logic [NE-1:0] irq_stat;
   logic [NE-1:0] irq_mask;
   logic [fault_routing_pkg::EXT_PINS-1:0] ext_enable;
   logic [fault_routing_pkg::EXT_PINS-1:0] ext_polarity;
   logic [fault_routing_pkg::PWM_EV-1:0] pwm_ev_enable;
   logic [fault_routing_pkg::ANA_CMP-1:0] ana_enable;
   // Digital comparator settings
   logic [EW-1:0] dig_threshold [fault_routing_pkg::DIG_CMP];
   logic [fault_routing_pkg::DIG_CMP-1:0] dig_enable;
   logic [fault_routing_pkg::DIG_CMP-1:0] dig_above;
   // Routing and limit per fault module
   logic [NV-1:0] route [NF];
   logic [CW-1:0] fault_limit [NF];

   // ********************************************
   // APB decode
   // ********************************************
   // Transfer qualifiers
   wire access = PSEL_IN && PENABLE_IN;
   wire wr = access && PWRITE_IN;
   wire rd_setup = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
   // Fixed registers
   wire sel_ctrl = PADDR_IN == fault_routing_pkg::REG_CTRL;
   wire sel_status = PADDR_IN == fault_routing_pkg::REG_STATUS;
   wire sel_istat = PADDR_IN == fault_routing_pkg::REG_IRQ_STAT;
   wire sel_imask = PADDR_IN == fault_routing_pkg::REG_IRQ_MASK;
   wire sel_ext = PADDR_IN == fault_routing_pkg::REG_EXT_CFG;
   wire sel_pwm = PADDR_IN == fault_routing_pkg::REG_PWM_CFG;
   wire sel_ana = PADDR_IN == fault_routing_pkg::REG_ANA_CFG;
   // Offsets into the three register arrays
   wire [AW-1:0] dig_off = PADDR_IN - fault_routing_pkg::REG_DIG_BASE;
   wire [AW-1:0] route_off = PADDR_IN - fault_routing_pkg::REG_ROUTE_BASE;
   wire [AW-1:0] limit_off = PADDR_IN - fault_routing_pkg::REG_LIMIT_BASE;
   // Array hits: word aligned and inside the array
   wire sel_dig = PADDR_IN >= fault_routing_pkg::REG_DIG_BASE && dig_off[1:0] == 2'h0
                  && dig_off[AW-1:2] < (AW-2)'(fault_routing_pkg::DIG_CMP);
   wire sel_route = PADDR_IN >= fault_routing_pkg::REG_ROUTE_BASE && route_off[1:0] == 2'h0
                    && route_off[AW-1:2] < (AW-2)'(NF);
   wire sel_limit = PADDR_IN >= fault_routing_pkg::REG_LIMIT_BASE && limit_off[1:0] == 2'h0
                    && limit_off[AW-1:2] < (AW-2)'(NF);
   // Array indices from the word offsets
   wire [1:0] dig_idx = dig_off[3:2];
   wire [3:0] route_idx = route_off[5:2];
   wire [3:0] limit_idx = limit_off[5:2];
   // Anything else is refused with an error
   wire mapped = sel_ctrl || sel_status || sel_istat || sel_imask || sel_ext || sel_pwm
                 || sel_ana || sel_dig || sel_route || sel_limit;
   // Flags and the read answer
   logic [NF-1:0] fault_flag;
   fault_routing_pkg::bus_answer_t answer;

   // Read mux
   always_comb begin
      answer.rdata = fault_routing_pkg::RESET_ZERO;
      answer.err = !mapped;
      if (sel_ctrl) begin
         answer.rdata = DW'(global_fault_enable);
      end else if (sel_status) begin
         answer.rdata = DW'(fault_flag);
      end else if (sel_istat) begin
         answer.rdata = DW'(irq_stat);
      end else if (sel_imask) begin
         answer.rdata = DW'(irq_mask);
      end else if (sel_ext) begin
         answer.rdata = DW'({ext_polarity, 4'h0, ext_enable});
      end else if (sel_pwm) begin
         answer.rdata = DW'(pwm_ev_enable);
      end else if (sel_ana) begin
         answer.rdata = DW'(ana_enable);
      end else if (sel_dig) begin
         answer.rdata = DW'({dig_above[dig_idx], dig_enable[dig_idx], 7'h00, dig_threshold[dig_idx]});
      end else if (sel_route) begin
         answer.rdata = DW'(route[route_idx]);
      end else if (sel_limit) begin
         answer.rdata = DW'(fault_limit[limit_idx]);
      end
   end

   // Zero wait state slave, read data registered in the setup phase
   assign PREADY_OUT = 1'b1;
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         PRDATA_OUT <= '0;
      end else if (rd_setup) begin
         PRDATA_OUT <= answer.rdata;
      end
   end
   // Error only in the access phase
   assign PSLVERR_OUT = access && answer.err;

   // Scalar configuration writes
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         global_fault_enable <= 1'b0;
         irq_mask <= '0;
         ext_enable <= '0;
         ext_polarity <= '0;
         pwm_ev_enable <= '0;
         ana_enable <= '0;
      end else if (wr) begin
         if (sel_ctrl) global_fault_enable <= PWDATA_IN[0];
         if (sel_imask) irq_mask <= PWDATA_IN[NE-1:0];
         if (sel_ext) begin
            ext_enable <= PWDATA_IN[fault_routing_pkg::EXT_PINS-1:0]; // R15
            ext_polarity <= PWDATA_IN[fault_routing_pkg::EXT_POL_LSB +: fault_routing_pkg::EXT_PINS];
         end
         if (sel_pwm) pwm_ev_enable <= PWDATA_IN[fault_routing_pkg::PWM_EV-1:0];
         if (sel_ana) ana_enable <= PWDATA_IN[fault_routing_pkg::ANA_CMP-1:0];
      end
   end

   // ********************************************
   // Fault event sources
   // ********************************************
   // One bit per fault event, in package order
   logic [NV-1:0] events;
   genvar d;
   generate
      for (d = 0; d < fault_routing_pkg::DIG_CMP; d++) begin : g_dig
         // Error sample compared by this comparator
         wire [EW-1:0] sample = ERROR_ADC_IN[d*EW +: EW];
         // Threshold registers
         always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               dig_threshold[d] <= '0;
               dig_enable[d] <= 1'b0;
               dig_above[d] <= 1'b0;
            end else if (wr && sel_dig && dig_idx == 2'(d)) begin
               dig_threshold[d] <= PWDATA_IN[EW-1:0];
               dig_enable[d] <= PWDATA_IN[fault_routing_pkg::DIG_EN_BIT];
               dig_above[d] <= PWDATA_IN[fault_routing_pkg::DIG_ABOVE_BIT];
            end
         end
         // Crossing above or below the threshold
         assign events[fault_routing_pkg::EV_DIG + d] = dig_enable[d]
            && (dig_above[d] ? sample > dig_threshold[d] : sample < dig_threshold[d]); // R13
      end
   endgenerate

   // Synchronised comparator, pin, clock and conduction events
   assign events[fault_routing_pkg::EV_ANA +: fault_routing_pkg::ANA_CMP] =
      pin_sync[0 +: fault_routing_pkg::ANA_CMP] & ana_enable; // R14
   assign events[fault_routing_pkg::EV_EXT +: fault_routing_pkg::EXT_PINS] =
      (pin_sync[fault_routing_pkg::ANA_CMP +: fault_routing_pkg::EXT_PINS] ^ ext_polarity) & ext_enable; // R15
   assign events[fault_routing_pkg::EV_PWM +: fault_routing_pkg::PWM_EV] = PWM_EVENT_IN & pwm_ev_enable; // R16
   assign events[fault_routing_pkg::EV_CLK] = pin_sync[NPIN-3]; // R17
   assign events[fault_routing_pkg::EV_CLK + 1] = pin_sync[NPIN-2]; // R17
   assign events[fault_routing_pkg::EV_DCM] = pin_sync[NPIN-1]; // R18

   // ********************************************
   // Fault modules, four per engine
   // ********************************************
   genvar f;
   generate
      for (f = 0; f < NF; f++) begin : g_mod
         localparam int ENG = f / NM;
         // Engine controls shared by its four modules
         wire ch_en = ENGINE_IN[ENG].channel_enable;
         wire cyc = ENGINE_IN[ENG].cycle_start;
         wire gated = !ch_en || !global_fault_enable;
         // Any selected event, any engine may pick the same one
         wire fault_in = |(events & route[f]); // R11 R12
         // Seen marks a detection already taken this cycle
         logic seen;
         logic [CW:0] count;
         wire [CW:0] next_count = count + (CW+1)'(1);
         // Counter saturates rather than wrapping to zero
         wire [CW:0] count_max = {1'b1, {CW{1'b1}}};
         wire over_limit = next_count > (CW+1)'(fault_limit[f]);
         // Route and limit registers
         always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               route[f] <= '0;
               fault_limit[f] <= '0;
            end else if (wr) begin
               if (sel_route && route_idx == 4'(f)) route[f] <= PWDATA_IN[NV-1:0];
               if (sel_limit && limit_idx == 4'(f)) fault_limit[f] <= PWDATA_IN[CW-1:0];
            end
         end
         // Per-cycle detection and consecutive counter
         always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               seen <= 1'b0;
               count <= '0;
               fault_flag[f] <= 1'b0;
            end else if (gated) begin // R6 R7
               seen <= 1'b0;
               count <= '0;
               fault_flag[f] <= 1'b0; // R5
            end else begin
               if (cyc) begin
                  seen <= 1'b0;
                  if (!seen) count <= '0; // R4
               end else if (fault_in && !seen) begin
                  seen <= 1'b1; // R2
                  if (count != count_max) count <= next_count;
                  if (over_limit) fault_flag[f] <= 1'b1; // R3
               end
            end
         end
      end
   endgenerate
   // Flags leave the block as registered
   assign FAULT_FLAG_OUT = fault_flag;

   // ********************************************
   // Engine outputs and cycle-by-cycle block
   // ********************************************
   genvar e;
   generate
      for (e = 0; e < NE; e++) begin : g_eng
         wire [NM-1:0] fl = fault_flag[e*NM +: NM]; // R1
         // Set and clear causes of the truncation
         wire trunc_set = ENGINE_IN[e].pcm_trip || fl[fault_routing_pkg::MOD_CYCLE_BY_CYCLE];
         wire trunc_clear = ENGINE_IN[e].cycle_start || !ENGINE_IN[e].channel_enable;
         logic trunc;
         // One cycle-by-cycle block: peak current or its module ends the pulse
         always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin // R8
            if (!RST_B_IN) begin
               trunc <= 1'b0;
            end else if (trunc_clear) begin
               trunc <= 1'b0;
            end else if (trunc_set) begin
               trunc <= 1'b1; // R9
            end
         end
         // Outputs towards the engine
         assign CYCLE_BY_CYCLE_TRUNC_OUT[e] = trunc;
         assign SHUTDOWN_A_OUT[e] = fl[fault_routing_pkg::MOD_A] || fl[fault_routing_pkg::MOD_AB]
                                    || fl[fault_routing_pkg::MOD_CYCLE_BY_CYCLE]; // R10
         assign SHUTDOWN_B_OUT[e] = fl[fault_routing_pkg::MOD_B] || fl[fault_routing_pkg::MOD_AB]; // R10
      end
   endgenerate

   // ********************************************
   // Interrupt: first flag in an engine that had none
   // ********************************************
   // Any flag of each engine, now and one clock ago
   logic [NE-1:0] any_prev;
   logic [NE-1:0] any_now;
   always_comb begin
      for (int i = 0; i < NE; i++) begin
         any_now[i] = |fault_flag[i*NM +: NM];
      end
   end
   // New flags, software clears and the next status
   wire [NE-1:0] rise = any_now & ~any_prev;
   wire [NE-1:0] clr = (wr && sel_istat) ? PWDATA_IN[NE-1:0] : '0;
   wire [NE-1:0] next_irq_stat = (irq_stat & ~clr) | rise;

   // Sticky bits, set wins over clear
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         any_prev <= '0;
         irq_stat <= '0;
      end else begin
         any_prev <= any_now;
         irq_stat <= next_irq_stat;
      end
   end
   assign IRQ_OUT = |(irq_stat & irq_mask);
endmodule
`default_nettype wire

// >>> verif/pwm_engine_model.sv
`default_nettype none
module pwm_engine_model #(
   parameter int PERIOD = 8
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // Bench controls
   input wire logic [3:0] enable_in,
   input wire logic [3:0] trip_in,
   // Engine side
   output var fault_routing_pkg::engine_ctrl_t [3:0] engine_out
);
   logic [7:0] phase;
   logic start;
   // Switching cycle counter with a one-cycle boundary pulse
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         phase <= 8'h00;
         start <= 1'b0;
      end else begin
         phase <= (phase == 8'(PERIOD - 1)) ? 8'h00 : phase + 8'h01;
         start <= (phase == 8'(PERIOD - 1));
      end
   end
   // Controller lowers the enable to clear latched flags
   always_comb begin
      for (int e = 0; e < 4; e++) begin
         engine_out[e] = '{channel_enable: enable_in[e], cycle_start: start, pcm_trip: trip_in[e]};
      end
   end
endmodule
`default_nettype wire

// >>> verif/fault_routing_asserts.sv
`default_nettype none
module fault_routing_asserts (
   // Clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   // APB
   input wire logic PSEL_IN,
   input wire logic PENABLE_IN,
   input wire logic PWRITE_IN,
   input wire logic [11:0] PADDR_IN,
   input wire logic [31:0] PRDATA_OUT,
   input wire logic PREADY_OUT,
   input wire logic PSLVERR_OUT,
   // Engines
   input wire fault_routing_pkg::engine_ctrl_t [3:0] ENGINE_IN,
   input wire logic [3:0] SHUTDOWN_A_OUT,
   input wire logic [3:0] SHUTDOWN_B_OUT,
   input wire logic [3:0] CYCLE_BY_CYCLE_TRUNC_OUT,
   input wire logic [15:0] FAULT_FLAG_OUT
);
   // *****
   // Helper state
   // *****
   logic [15:0] dis, flag_q, clr_q;
   logic [3:0] shut_a, shut_b, trip, cause, trip_q, cause_q, trunc_q;
   logic [1:0] wr_sh;
   logic ctrl_wr;
   // Per-engine views of controls and flags
   always_comb begin
      for (int e = 0; e < 4; e++) begin
         dis[4*e +: 4] = {4{!ENGINE_IN[e].channel_enable}};
         shut_a[e] = |FAULT_FLAG_OUT[4*e +: 3];
         shut_b[e] = FAULT_FLAG_OUT[4*e+1] | FAULT_FLAG_OUT[4*e+3];
         trip[e] = ENGINE_IN[e].pcm_trip & ENGINE_IN[e].channel_enable & !ENGINE_IN[e].cycle_start;
         cause[e] = ENGINE_IN[e].pcm_trip | FAULT_FLAG_OUT[4*e];
      end
   end
   assign ctrl_wr = PSEL_IN & PENABLE_IN & PWRITE_IN & (PADDR_IN == fault_routing_pkg::REG_CTRL);
   // Snapshots of the previous edge
   always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         {flag_q, clr_q, trip_q, cause_q, trunc_q, wr_sh} <= '0;
      end else begin
         flag_q <= FAULT_FLAG_OUT;
         clr_q <= dis;
         trip_q <= trip;
         cause_q <= cause;
         trunc_q <= CYCLE_BY_CYCLE_TRUNC_OUT;
         wr_sh <= {wr_sh[0], ctrl_wr};
      end
   end
   // *****
   // Properties
   // *****
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   sequence s_access; PSEL_IN && PENABLE_IN; endsequence
   sequence s_refused_read; s_access ##0 (!PWRITE_IN && PSLVERR_OUT); endsequence
   property p_shut_a; SHUTDOWN_A_OUT == shut_a; endproperty
   property p_shut_b; SHUTDOWN_B_OUT == shut_b; endproperty
   property p_clear; (FAULT_FLAG_OUT & clr_q) == 16'h0000; endproperty
   property p_hold; (flag_q & ~FAULT_FLAG_OUT & ~clr_q & ~{16{|wr_sh}}) == 16'h0000; endproperty
   property p_trip; (trip_q & ~CYCLE_BY_CYCLE_TRUNC_OUT) == 4'h0; endproperty
   property p_trunc_cause; (CYCLE_BY_CYCLE_TRUNC_OUT & ~trunc_q & ~cause_q) == 4'h0; endproperty
   property p_ready; s_access |-> PREADY_OUT; endproperty
   property p_slverr; PSLVERR_OUT |-> s_access; endproperty
   property p_refused; s_refused_read |-> PRDATA_OUT == 32'h0000_0000; endproperty
   a_shut_a: assert property (p_shut_a) else $error("shutdown A mismatch");
   a_shut_b: assert property (p_shut_b) else $error("shutdown B mismatch");
   a_clear: assert property (p_clear) else $error("flag set while disabled");
   a_hold: assert property (p_hold) else $error("flag dropped without cause");
   a_trip: assert property (p_trip) else $error("trip not truncated");
   a_trunc_cause: assert property (p_trunc_cause) else $error("truncation without cause");
   a_ready: assert property (p_ready) else $error("access not ready");
   a_slverr: assert property (p_slverr) else $error("error outside access");
   a_refused: assert property (p_refused) else $error("refused read not zero");
endmodule
bind fault_routing_protection fault_routing_asserts fault_routing_asserts_inst (.SYS_CLK_IN(SYS_CLK_IN),
   .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
   .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
   .ENGINE_IN(ENGINE_IN), .SHUTDOWN_A_OUT(SHUTDOWN_A_OUT), .SHUTDOWN_B_OUT(SHUTDOWN_B_OUT),
   .CYCLE_BY_CYCLE_TRUNC_OUT(CYCLE_BY_CYCLE_TRUNC_OUT), .FAULT_FLAG_OUT(FAULT_FLAG_OUT));
`default_nettype wire

// >>> verif/tb.sv
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_b, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [22:0] src;
   logic [35:0] adc;
   logic [3:0] en, trip, sa, sb, trunc;
   logic [15:0] flags;
   fault_routing_pkg::engine_ctrl_t [3:0] eng;
   int miscompares, samples_checked;
   always #50 clk = ~clk;
   // Error ADC samples sit above or below the comparator threshold
   always_comb for (int d = 0; d < 4; d++) adc[9*d +: 9] = src[d] ? 9'h0c8 : 9'h032;
   pwm_engine_model pwm_engine_model_inst (.clk_in(clk), .rst_b_in(rst_b), .enable_in(en), .trip_in(trip),
      .engine_out(eng));
   fault_routing_protection fault_routing_protection_inst (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ERROR_ADC_IN(adc), .ANALOG_CMP_IN(src[10:4]),
      .EXT_FAULT_PIN_IN(src[14:11]), .PWM_EVENT_IN(src[19:15]), .HF_OSC_FAIL_IN(src[20]),
      .LF_OSC_FAIL_IN(src[21]), .DCM_DETECT_IN(src[22]), .ENGINE_IN(eng), .SHUTDOWN_A_OUT(sa),
      .SHUTDOWN_B_OUT(sb), .CYCLE_BY_CYCLE_TRUNC_OUT(trunc), .FAULT_FLAG_OUT(flags), .IRQ_OUT(irq));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // APB cycle: setup, then access held until ready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         miscompares++;
         $display("Error at %0t: no ready on the bus", $time);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdchk(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(q, x);
      chk(32'(e), 32'(xe));
   endtask
   task wait_cs;
      do @(posedge clk); while (eng[0].cycle_start !== 1'b1);
   endtask
   // Pulse events for three clocks inside each of n switching cycles
   task fcycle(input int n, input logic [22:0] v);
      repeat (n) begin
         wait_cs;
         repeat (2) @(posedge clk);
         src <= v;
         repeat (3) @(posedge clk);
         src <= 23'h0;
      end
      repeat (2) @(posedge clk);
   endtask
   task clear_eng;
      @(posedge clk) en <= 4'h0;
      repeat (2) @(posedge clk);
      en <= 4'hf;
   endtask
   task t_sources;
      wr(fault_routing_pkg::REG_CTRL, 32'h1);
      wr(fault_routing_pkg::REG_EXT_CFG, 32'h0000_000f);
      wr(fault_routing_pkg::REG_PWM_CFG, 32'h0000_001f);
      wr(fault_routing_pkg::REG_ANA_CFG, 32'h0000_007f);
      for (int d = 0; d < 4; d++) wr(fault_routing_pkg::REG_DIG_BASE + 12'(4 * d), 32'h0003_0064);
      rdchk(fault_routing_pkg::REG_DIG_BASE + 12'h00c, 32'h0003_0064, 1'b0);
      for (int b = 0; b < 23; b++) begin
         wr(fault_routing_pkg::REG_ROUTE_BASE + 12'h008, (32'h1 << b) | (32'h1 << ((b + 1) % 23)));
         fcycle(1, 23'h1 << ((b + 2) % 23));
         chk(32'(flags), 32'h0);
         fcycle(1, 23'h1 << b);
         chk(32'(flags), 32'h4);
         chk(32'({sb, sa}), 32'h01);
         clear_eng;
      end
   endtask
   task t_count;
      wr(fault_routing_pkg::REG_ROUTE_BASE + 12'h008, 32'h0000_8000);
      wr(fault_routing_pkg::REG_LIMIT_BASE + 12'h008, 32'h2);
      fcycle(2, 23'h0_8000);
      fcycle(1, 23'h0);
      fcycle(2, 23'h0_8000);
      chk(32'(flags), 32'h0);
      fcycle(1, 23'h0_8000);
      chk(32'(flags), 32'h4);
      fcycle(2, 23'h0);
      chk(32'(flags), 32'h4);
      clear_eng;
      wr(fault_routing_pkg::REG_LIMIT_BASE + 12'h008, 32'h0);
   endtask
   task t_fanout;
      for (int f = 0; f < 16; f++) wr(fault_routing_pkg::REG_ROUTE_BASE + 12'(4 * f), 32'h0000_8000);
      wr(fault_routing_pkg::REG_IRQ_MASK, 32'hf);
      fcycle(1, 23'h0_8000);
      chk(32'(flags), 32'hffff);
      chk(32'({sb, sa}), 32'hff);
      chk(32'(irq), 32'h1);
      rdchk(fault_routing_pkg::REG_IRQ_STAT, 32'hf, 1'b0);
      @(posedge clk) en <= 4'he;
      repeat (2) @(posedge clk);
      chk(32'(flags), 32'hfff0);
      wr(fault_routing_pkg::REG_IRQ_STAT, 32'hf);
      rdchk(fault_routing_pkg::REG_IRQ_STAT, 32'h0, 1'b0);
      chk(32'(irq), 32'h0);
      clear_eng;
      wr(fault_routing_pkg::REG_CTRL, 32'h0);
      fcycle(1, 23'h0_8000);
      chk(32'(flags), 32'h0);
   endtask
   task t_cbc;
      wait_cs;
      trip <= 4'h2;
      @(posedge clk) trip <= 4'h0;
      @(posedge clk) chk(32'(trunc), 32'h2);
      wait_cs;
      repeat (2) @(posedge clk);
      chk(32'(trunc), 32'h0);
   endtask
   task tally_and_finish;
      $display("Checks %0d, errors %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      {psel, penable, pwrite, paddr, pwdata, src, en, trip, rst_b} = '0;
      miscompares = 0;
      samples_checked = 0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      en <= 4'hf;
      rdchk(fault_routing_pkg::REG_STATUS, 32'h0, 1'b0);
      rdchk(fault_routing_pkg::REG_IRQ_MASK, 32'h0, 1'b0);
      rdchk(12'h3f0, 32'h0, 1'b1);
      t_sources;
      t_count;
      t_fanout;
      t_cbc;
      tally_and_finish;
   end
   // Watchdog
   initial begin
      #2000000;
      miscompares++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
